// ### vspg_pkg.sv
// Constants, types and pattern table of the video sync pulse generator.
// Assumes one 25 MHz system clock shared by every module of the block.

package vspg_pkg;

	// ---------------------------------------------------------------
	// Clock and widths
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int LINE_W = 11;
	localparam int CODE_W = 10;
	localparam int POS_W = 3;
	localparam int HPOS_W = 12;
	localparam int VSYNC_W = 5;
	localparam int VBLANK_W = 7;
	localparam int SHARED_BIT = 9;

	// ---------------------------------------------------------------
	// Line-number decode of the shared top input
	// ---------------------------------------------------------------
	localparam logic [1:0] TOP_WEIGHTS_HIGH = 2'h1;
	localparam logic [1:0] TOP_WEIGHTS_LOW = 2'h2;
	localparam logic [LINE_W-1:0] LINES_MIN = 11'h200;
	localparam logic [LINE_W-1:0] LINES_MAX = 11'h5FF;

	// ---------------------------------------------------------------
	// Pulse placement as fractions of a half line
	// ---------------------------------------------------------------
	localparam int FRONT_SHIFT = 5;
	localparam int SYNC_SHIFT = 3;
	localparam int BLANK_SHIFT_A = 2;
	localparam int BLANK_SHIFT_B = 3;
	localparam int CLAMP_SHIFT = 4;

	// ---------------------------------------------------------------
	// Pattern table
	// ---------------------------------------------------------------
	localparam int LINES_525 = 525;
	localparam int LINES_625 = 625;
	localparam int LINES_735 = 735;
	localparam int LINES_875 = 875;
	localparam int LINES_1023 = 1023;
	localparam int FIELD_60_HZ = 60;
	localparam int FIELD_50_HZ = 50;
	localparam logic [VSYNC_W-1:0] VSYNC_60 = 5'h06;
	localparam logic [VSYNC_W-1:0] VSYNC_50 = 5'h05;

	typedef enum logic [2:0] {
		VSPG_PAT_525 = 3'h0,
		VSPG_PAT_625 = 3'h1,
		VSPG_PAT_735 = 3'h2,
		VSPG_PAT_875 = 3'h3,
		VSPG_PAT_1023 = 3'h4
	} vspg_pattern_type;

	typedef enum logic [1:0] {
		VSPG_LOCK_INT = 2'h0,
		VSPG_LOCK_SYNC = 2'h1,
		VSPG_LOCK_RESET = 2'h2
	} vspg_lock_type;

	typedef struct packed {
		logic [HPOS_W-1:0] ratio;
		logic [VSYNC_W-1:0] vsync_half;
		logic [VBLANK_W-1:0] vblank_half;
	} vspg_timing_type;

	typedef struct packed {
		logic ext_h;
		logic ext_v;
	} vspg_ext_type;

	typedef struct packed {
		logic comp_sync;
		logic comp_blank;
		logic vert;
		logic horiz;
		logic double_rate_n;
		logic merged;
		logic horiz_blank;
		logic clamp;
		logic main_sync;
		logic field;
	} vspg_pulse_type;

	// Clock cycles per half line: clock over lines times field rate
	function automatic vspg_timing_type vspg_timing(input logic [2:0] code);
		vspg_timing_type t;
		t = '0;
		case (code)
			VSPG_PAT_525: begin
				t.ratio = HPOS_W'(CLK_HZ / (LINES_525 * FIELD_60_HZ));
				t.vsync_half = VSYNC_60;
				t.vblank_half = 7'h28;
			end
			VSPG_PAT_735: begin
				t.ratio = HPOS_W'(CLK_HZ / (LINES_735 * FIELD_60_HZ));
				t.vsync_half = VSYNC_60;
				t.vblank_half = 7'h38;
			end
			VSPG_PAT_875: begin
				t.ratio = HPOS_W'(CLK_HZ / (LINES_875 * FIELD_50_HZ));
				t.vsync_half = VSYNC_50;
				t.vblank_half = 7'h46;
			end
			VSPG_PAT_1023: begin
				t.ratio = HPOS_W'(CLK_HZ / (LINES_1023 * FIELD_60_HZ));
				t.vsync_half = VSYNC_60;
				t.vblank_half = 7'h4E;
			end
			default: begin
				t.ratio = HPOS_W'(CLK_HZ / (LINES_625 * FIELD_50_HZ));
				t.vsync_half = VSYNC_50;
				t.vblank_half = 7'h32;
			end
		endcase
		return t;
	endfunction

endpackage

// ### vspg_sync2.sv
// Two-stage synchroniser for the external lock inputs.
// Assumes the inputs are asynchronous pins; only stage two is read.
`timescale 1ns/1ps

module vspg_sync2 #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (!i_reset_n) begin
					meta_reg[g] <= 1'b0;
					sync_reg[g] <= 1'b0;
				end else begin
					meta_reg[g] <= i_async[g];
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign o_sync = sync_reg;

endmodule

// ### vspg_hdiv.sv
// Horizontal divider: clock cycles within one half line.
// Assumes the ratio is steady except across pattern changes.
`timescale 1ns/1ps

module vspg_hdiv #(
	parameter int HPOS_W = 12
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Control
	input wire logic i_align,
	input wire logic [HPOS_W-1:0] i_ratio,
	// Position
	output logic [HPOS_W-1:0] o_hpos,
	output logic o_tick
);

	logic [HPOS_W-1:0] hpos_reg;
	logic [HPOS_W-1:0] hpos_next;
	wire logic [HPOS_W-1:0] last_pos = i_ratio - HPOS_W'(1);
	wire logic at_end = hpos_reg >= last_pos;

	// Wrap each half line; an external edge restarts the count
	assign hpos_next = (i_align || at_end) ? '0 : hpos_reg + HPOS_W'(1);

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			hpos_reg <= '0;
		end else begin
			hpos_reg <= hpos_next;
		end
	end

	assign o_hpos = hpos_reg;
	assign o_tick = at_end && !i_align;

endmodule

// ### vspg_top.sv
// Video sync pulse generator: half-line divider, field line counter
// and pulse decode, with optional lock to external timing inputs.
// Assumes a free-running 25 MHz clock and steady programming inputs.
`timescale 1ns/1ps

// Behaviour
// [RULE_01] Divide clock to double line rate pulses
// [RULE_02] Eleven-bit line counter steps on those pulses
// [RULE_03] Controller sets line count by binary code
// [RULE_04] Shared top input limits range 512-1535
// [RULE_05] Count matches code: clear, restart next pulse
// [RULE_06] Vertical pulse every field, code per frame
// [RULE_07] Even count: no half line, else interlaced
// [RULE_08] Controller drives three-bit pulse position code
// [RULE_09] Five standard patterns by code and clock
// [RULE_10] Clock source must be symmetrical
// [RULE_11] Composite sync, blanking and separate pulses
// [RULE_12] Horizontal blanking and clamp on own outputs
// [RULE_13] Lock to external sync or reset pulses
// [RULE_14] Merged-signal lock uses line, field-reset inputs
// [RULE_15] Select chooses main sync output content
// [RULE_16] Divider ratio gives twice the line rate
module vspg_top #(
	parameter int LINE_W = 11,
	parameter int HPOS_W = 12
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Programming inputs
	input wire logic [9:0] i_line_code,
	input wire logic i_position_code_bit_a,
	input wire logic i_position_code_bit_b,
	input wire logic i_position_code_bit_c,
	input wire logic [1:0] i_lock_mode,
	input wire logic i_sync_select,
	// External timing pins
	input wire logic i_ext_h,
	input wire logic i_ext_v,
	// Pulse outputs
	output logic o_comp_sync,
	output logic o_comp_blank,
	output logic o_vert_pulse,
	output logic o_horiz_pulse,
	output logic o_double_rate_line_pulse_n,
	output logic o_merged_line_field_pulse,
	output logic o_horiz_blank,
	output logic o_clamp,
	output logic o_main_sync,
	output logic o_field
);

	// ---------------------------------------------------------------
	// Parameter checks
	// ---------------------------------------------------------------
	generate
		if (LINE_W != vspg_pkg::LINE_W) begin : g_bad_line_w
			$error("LINE_W must match the line counter width");
		end
		if (HPOS_W != vspg_pkg::HPOS_W) begin : g_bad_hpos_w
			$error("HPOS_W must match the half-line position width");
		end
	endgenerate

	// ---------------------------------------------------------------
	// External inputs
	// ---------------------------------------------------------------
	vspg_pkg::vspg_ext_type ext_sync;
	vspg_pkg::vspg_ext_type ext_d_reg;

	vspg_sync2 #(
		.WIDTH(2)
	) u_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_ext_h, i_ext_v}),
		.o_sync(ext_sync)
	);

	wire logic lock_on = i_lock_mode != vspg_pkg::VSPG_LOCK_INT;
	wire logic lock_reset = i_lock_mode == vspg_pkg::VSPG_LOCK_RESET;
	wire logic h_align = lock_on && ext_sync.ext_h &&
		!ext_d_reg.ext_h; // [RULE_13]
	wire logic v_align = lock_on && ext_sync.ext_v &&
		!ext_d_reg.ext_v; // [RULE_13]

	// ---------------------------------------------------------------
	// Pattern and line-number decode
	// ---------------------------------------------------------------
	wire logic [2:0] pos_code = {i_position_code_bit_a, i_position_code_bit_b,
		i_position_code_bit_c}; // [RULE_08]
	wire vspg_pkg::vspg_timing_type timing =
		vspg_pkg::vspg_timing(pos_code); // [RULE_09]
	wire logic [HPOS_W-1:0] ratio = timing.ratio; // [RULE_16]
	wire logic [1:0] top_weights = i_line_code[vspg_pkg::SHARED_BIT] ?
		vspg_pkg::TOP_WEIGHTS_HIGH : vspg_pkg::TOP_WEIGHTS_LOW; // [RULE_04]
	wire logic [LINE_W-1:0] line_target = {top_weights,
		i_line_code[vspg_pkg::SHARED_BIT-1:0]}; // [RULE_03]
	wire logic [LINE_W-1:0] target_m1 = line_target - LINE_W'(1);

	// ---------------------------------------------------------------
	// Horizontal divider
	// ---------------------------------------------------------------
	logic [HPOS_W-1:0] hpos;
	logic tick;

	vspg_hdiv #(
		.HPOS_W(HPOS_W)
	) u_hdiv (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_align(h_align),
		.i_ratio(ratio),
		.o_hpos(hpos),
		.o_tick(tick) // [RULE_01]
	);

	// ---------------------------------------------------------------
	// Line phase, vertical counter and field
	// ---------------------------------------------------------------
	logic phase_reg;
	logic phase_next;
	logic [LINE_W-1:0] vcount_reg;
	logic [LINE_W-1:0] vcount_next;
	logic field_reg;
	logic field_next;

	wire logic vmatch = vcount_reg == target_m1; // [RULE_05]

	// Line phase runs free of the field count, so an odd count ends a
	// field in mid line and an even count on a line start
	assign phase_next = h_align ? 1'b0 :
		(tick ? !phase_reg : phase_reg); // [RULE_07]

	assign vcount_next = v_align ? '0 :
		(tick ? (vmatch ? '0 : vcount_reg + LINE_W'(1)) : vcount_reg); // [RULE_02]

	assign field_next = (v_align && lock_reset) ? 1'b0 : // [RULE_14]
		((v_align || (tick && vmatch)) ? !field_reg : field_reg); // [RULE_06]

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ext_d_reg <= '0;
			phase_reg <= 1'b0;
			vcount_reg <= '0;
			field_reg <= 1'b0;
		end else begin
			ext_d_reg <= ext_sync;
			phase_reg <= phase_next;
			vcount_reg <= vcount_next;
			field_reg <= field_next;
		end
	end

	// ---------------------------------------------------------------
	// Pulse windows within the half line
	// ---------------------------------------------------------------
	wire logic [HPOS_W-1:0] front_w = ratio >> vspg_pkg::FRONT_SHIFT;
	wire logic [HPOS_W-1:0] sync_w = ratio >> vspg_pkg::SYNC_SHIFT;
	wire logic [HPOS_W-1:0] sync_end = front_w + sync_w;
	wire logic [HPOS_W-1:0] broad_end = front_w + ratio - sync_w;
	wire logic [HPOS_W-1:0] blank_end = (ratio >> vspg_pkg::BLANK_SHIFT_A) +
		(ratio >> vspg_pkg::BLANK_SHIFT_B);
	wire logic [HPOS_W-1:0] clamp_end = sync_end +
		(ratio >> vspg_pkg::CLAMP_SHIFT);

	wire logic in_sync = hpos >= front_w && hpos < sync_end;
	wire logic in_broad = hpos >= front_w && hpos < broad_end;
	wire logic in_hblank = !phase_reg && hpos < blank_end;
	wire logic in_clamp = !phase_reg && hpos >= sync_end && hpos < clamp_end;

	wire logic vsync_win = vcount_reg < LINE_W'(timing.vsync_half); // [RULE_06]
	wire logic vblank_win = vcount_reg < LINE_W'(timing.vblank_half);
	wire logic frame_reset = vcount_reg == '0 && !field_reg;

	// ---------------------------------------------------------------
	// Pulse decode
	// ---------------------------------------------------------------
	vspg_pkg::vspg_pulse_type pulse_reg;
	vspg_pkg::vspg_pulse_type pulse_next;

	wire logic h_pulse = !phase_reg && in_sync; // [RULE_11]
	wire logic pulse_double = in_sync; // [RULE_11]
	wire logic comp_sync = vsync_win ? in_broad : h_pulse; // [RULE_11]
	wire logic merged = pulse_double || (frame_reset && in_broad); // [RULE_11]

	assign pulse_next.comp_sync = comp_sync;
	assign pulse_next.comp_blank = in_hblank || vblank_win; // [RULE_11]
	assign pulse_next.vert = vsync_win;
	assign pulse_next.horiz = h_pulse;
	assign pulse_next.double_rate_n = !pulse_double;
	assign pulse_next.merged = merged;
	assign pulse_next.horiz_blank = in_hblank; // [RULE_12]
	assign pulse_next.clamp = in_clamp && !vblank_win; // [RULE_12]
	assign pulse_next.main_sync = i_sync_select ? merged : comp_sync; // [RULE_15]
	assign pulse_next.field = field_reg;

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			pulse_reg <= '0;
			pulse_reg.double_rate_n <= 1'b1;
		end else begin
			pulse_reg <= pulse_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_comp_sync = pulse_reg.comp_sync;
	assign o_comp_blank = pulse_reg.comp_blank;
	assign o_vert_pulse = pulse_reg.vert;
	assign o_horiz_pulse = pulse_reg.horiz;
	assign o_double_rate_line_pulse_n = pulse_reg.double_rate_n;
	assign o_merged_line_field_pulse = pulse_reg.merged;
	assign o_horiz_blank = pulse_reg.horiz_blank;
	assign o_clamp = pulse_reg.clamp;
	assign o_main_sync = pulse_reg.main_sync;
	assign o_field = pulse_reg.field;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence s_half_line_end;
		tick && !h_align;
	endsequence

	sequence s_restart;
		(hpos == '0) ##1 (hpos == HPOS_W'(1) || $past(h_align));
	endsequence

	property p_half_line_wrap;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_half_line_end ##0 $stable(ratio) |=> s_restart;
	endproperty
	a_half_line_wrap: assert property (p_half_line_wrap) // [RULE_01]
		else $error("half line did not wrap");

	property p_ratio_tick;
		@(posedge i_clk) disable iff (!i_reset_n)
		tick && $stable(ratio) && !$past(h_align) |-> hpos == ratio - HPOS_W'(1);
	endproperty
	a_ratio_tick: assert property (p_ratio_tick) // [RULE_16]
		else $error("tick off the ratio");

	property p_vcount_step;
		@(posedge i_clk) disable iff (!i_reset_n)
		tick && !vmatch && !v_align |=> vcount_reg == $past(vcount_reg) + LINE_W'(1);
	endproperty
	a_vcount_step: assert property (p_vcount_step) // [RULE_02]
		else $error("line count did not step");

	property p_vcount_hold;
		@(posedge i_clk) disable iff (!i_reset_n)
		!tick && !v_align |=> $stable(vcount_reg);
	endproperty
	a_vcount_hold: assert property (p_vcount_hold) // [RULE_02]
		else $error("line count moved");

	property p_match_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		tick && vmatch && !v_align |=>
			vcount_reg == '0 && field_reg != $past(field_reg);
	endproperty
	a_match_clear: assert property (p_match_clear) // [RULE_05]
		else $error("match did not clear");

	property p_range;
		@(posedge i_clk) disable iff (!i_reset_n)
		line_target >= vspg_pkg::LINES_MIN && line_target <= vspg_pkg::LINES_MAX &&
			line_target[vspg_pkg::SHARED_BIT] ==
			i_line_code[vspg_pkg::SHARED_BIT];
	endproperty
	a_range: assert property (p_range) // [RULE_04]
		else $error("line count out of range");

	property p_ext_lock;
		@(posedge i_clk) disable iff (!i_reset_n)
		v_align |=> vcount_reg == '0 ##0 (field_reg == 1'b0 || !$past(lock_reset));
	endproperty
	a_ext_lock: assert property (p_ext_lock) // [RULE_13]
		else $error("external lock ignored");

	property p_merged_has_double;
		@(posedge i_clk) disable iff (!i_reset_n)
		!o_double_rate_line_pulse_n |-> o_merged_line_field_pulse;
	endproperty
	a_merged_has_double: assert property (p_merged_has_double) // [RULE_11]
		else $error("double rate pulse missing from merged");

	property p_main_select;
		@(posedge i_clk) disable iff (!i_reset_n)
		##1 o_main_sync == ($past(i_sync_select) ?
			o_merged_line_field_pulse : o_comp_sync);
	endproperty
	a_main_select: assert property (p_main_select) // [RULE_15]
		else $error("main sync wrong source");

	property p_blank_clamp;
		@(posedge i_clk) disable iff (!i_reset_n)
		(o_horiz_blank |-> o_comp_blank) and
			(o_clamp |-> !o_horiz_pulse && !o_vert_pulse);
	endproperty
	a_blank_clamp: assert property (p_blank_clamp) // [RULE_12]
		else $error("blank or clamp misplaced");

endmodule

// ### vspg_video_sink.sv
// Video equipment model: measures the half-line and line pulses it receives.
// Assumes the pulses change only on the rising edge of the bench clock.
`timescale 1ns/1ps

module vspg_video_sink (
	// Clock
	input wire logic i_clk,
	// Received pulses
	input wire logic i_double_rate_n,
	input wire logic i_horiz,
	// Measurements in clock cycles, and a count of falling edges
	output int o_half_period,
	output int o_sync_width,
	output int o_line_period,
	output int o_falls
);
	int since_fall = 0;
	int since_rise = 0;
	int low_cnt = 0;
	logic prev_n = 1'b1;
	logic prev_h = 1'b0;

	// ----------------
	// Measurement
	// ----------------
	initial begin
		o_half_period = 0;
		o_sync_width = 0;
		o_line_period = 0;
		o_falls = 0;
	end

	always @(posedge i_clk) begin
		if (prev_n === 1'b1 && i_double_rate_n === 1'b0) begin
			o_half_period = since_fall;
			o_falls = o_falls + 1;
			since_fall = 0;
		end
		if (prev_n === 1'b0 && i_double_rate_n === 1'b1) begin
			o_sync_width = low_cnt;
			low_cnt = 0;
		end
		if (i_double_rate_n === 1'b0) begin
			low_cnt++;
		end
		if (prev_h === 1'b0 && i_horiz === 1'b1) begin
			o_line_period = since_rise;
			since_rise = 0;
		end
		since_fall++;
		since_rise++;
		prev_n = i_double_rate_n;
		prev_h = i_horiz;
	end
endmodule

// ### vspg_top_tb.sv
// Self-checking bench of the sync pulse generator with a video sink.
// Assumes a 25 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps

`define CHK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("[ERR] %0t got %0d exp %0d", $time, (got), (exp)); \
	end \
end

module vspg_top_tb;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [9:0] line_code = 10'h3FF;
	logic pa = 1'b1;
	logic pb = 1'b0;
	logic pc = 1'b0;
	logic [1:0] lock_mode = 2'h0;
	logic sync_select = 1'b0;
	logic ext_h = 1'b0;
	logic ext_v = 1'b0;
	logic o_comp_sync, o_comp_blank, o_vert_pulse, o_horiz_pulse;
	logic o_two_h_n, o_merged, o_horiz_blank, o_clamp, o_main_sync, o_field;
	int half_period, sync_width, line_period, falls;
	int n_fail = 0;
	int compares = 0;
	logic [31:0] seed = 32'h0000860F;

	// ----------------
	// Clock, design and sink
	// ----------------
	always #20 i_clk = ~i_clk;

	vspg_top i_vspg_top (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_line_code(line_code),
		.i_position_code_bit_a(pa),
		.i_position_code_bit_b(pb),
		.i_position_code_bit_c(pc),
		.i_lock_mode(lock_mode),
		.i_sync_select(sync_select),
		.i_ext_h(ext_h),
		.i_ext_v(ext_v),
		.o_comp_sync(o_comp_sync),
		.o_comp_blank(o_comp_blank),
		.o_vert_pulse(o_vert_pulse),
		.o_horiz_pulse(o_horiz_pulse),
		.o_double_rate_line_pulse_n(o_two_h_n),
		.o_merged_line_field_pulse(o_merged),
		.o_horiz_blank(o_horiz_blank),
		.o_clamp(o_clamp),
		.o_main_sync(o_main_sync),
		.o_field(o_field)
	);

	vspg_video_sink i_vspg_video_sink (
		.i_clk(i_clk),
		.i_double_rate_n(o_two_h_n),
		.i_horiz(o_horiz_pulse),
		.o_half_period(half_period),
		.o_sync_width(sync_width),
		.o_line_period(line_period),
		.o_falls(falls)
	);

	// ----------------
	// Helpers
	// ----------------
	function logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int exp_ratio(input int c);
		int lines;
		int hz;
		case (c)
			0: begin lines = 525; hz = 60; end
			2: begin lines = 735; hz = 60; end
			3: begin lines = 875; hz = 50; end
			4: begin lines = 1023; hz = 60; end
			default: begin lines = 625; hz = 50; end
		endcase
		return vspg_pkg::CLK_HZ / (lines * hz);
	endfunction

	task test_done();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task wait_falls(input int n);
		int start;
		int k;
		start = falls;
		for (k = 0; k < n * 2000 && falls < start + n; k++)
			@(negedge i_clk);
		if (falls < start + n) begin
			n_fail++;
			$display("[ERR] %0t no half-line pulse", $time);
		end
	endtask

	task pulse_pin(input bit vert);
		if (vert)
			ext_v = 1'b1;
		else
			ext_h = 1'b1;
		repeat (3) @(negedge i_clk);
		ext_h = 1'b0;
		ext_v = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask

	// Pulse the line pin at a random point, time the next sync pulse
	task lock_line(output int d);
		wait_falls(1);
		repeat (100 + next_rand() % 300) @(negedge i_clk);
		ext_h = 1'b1;
		d = 0;
		while (o_two_h_n !== 1'b0 && d < 100) begin
			@(negedge i_clk);
			d++;
			if (d == 3)
				ext_h = 1'b0;
		end
		ext_h = 1'b0;
	endtask

	initial begin
		#4000000;
		n_fail++;
		test_done();
	end

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		int r, cv, cc, nm, ns, d, k;
		logic old_field;
		repeat (6) @(negedge i_clk);
		i_reset_n = 1'b1;
		cv = 0;
		cc = 0;
		for (k = 0; k < 4000; k++) begin
			@(negedge i_clk);
			cv += (o_vert_pulse === 1'b1);
			cc += (o_clamp === 1'b1);
		end
		`CHK(cv, 6 * exp_ratio(4));
		`CHK(cc, 0);
		repeat (29000) @(negedge i_clk);
		for (k = 0; k < 1000 && o_horiz_pulse !== 1'b1; k++)
			@(negedge i_clk);
		`CHK(o_comp_sync, 1'b1);
		`CHK(o_comp_blank, 1'b1);
		`CHK(o_horiz_blank, 1'b1);
		`CHK(o_two_h_n, 1'b0);
		for (k = 0; k < 1000 && o_horiz_pulse === 1'b1; k++)
			@(negedge i_clk);
		cc = 0;
		while (o_clamp === 1'b1 && cc < 1000) begin
			cc++;
			@(negedge i_clk);
		end
		`CHK(cc, exp_ratio(4) >> 4);
		for (r = 0; r < 2; r++) begin
			sync_select = r[0];
			wait_falls(1);
			nm = 0;
			ns = 0;
			for (k = 0; k < 2 * exp_ratio(4) - 20; k++) begin
				nm += (o_main_sync === 1'b1);
				ns += ((r ? o_merged : o_comp_sync) === 1'b1);
				@(negedge i_clk);
			end
			`CHK(nm, ns);
		end
		for (r = 0; r < 6; r++) begin
			{pa, pb, pc} = r[2:0];
			line_code = 10'(next_rand());
			sync_select = 1'(next_rand());
			wait_falls(5);
			`CHK(half_period, exp_ratio(r));
			`CHK(sync_width, exp_ratio(r) >> 3);
			`CHK(line_period, 2 * exp_ratio(r));
		end
		{pa, pb, pc} = 3'h1;
		line_code = 10'h271;
		wait_falls(2);
		lock_mode = 2'h0;
		wait_falls(1);
		pulse_pin(1'b0);
		wait_falls(1);
		`CHK(half_period, exp_ratio(1));
		for (r = 1; r < 4; r++) begin
			lock_mode = r[1:0];
			lock_line(d);
			nm = exp_ratio(1) >> 5;
			`CHK(d >= nm && d <= nm + 8, 1'b1);
		end
		lock_mode = 2'h1;
		for (r = 0; r < 2; r++) begin
			old_field = o_field;
			pulse_pin(1'b1);
			repeat (4) @(negedge i_clk);
			`CHK(o_field, ~old_field);
			`CHK(o_vert_pulse, 1'b1);
		end
		lock_mode = 2'h2;
		for (r = 0; r < 2; r++) begin
			pulse_pin(1'b1);
			repeat (4) @(negedge i_clk);
			`CHK(o_field, 1'b0);
		end
		test_done();
	end
endmodule
